// >>> rtl/fps_consts.svh
// offsets, field positions, command codes and timing counts of the flash sequencer host
`ifndef FPS_CONSTS_SVH
`define FPS_CONSTS_SVH
// ---------------------------------------------------------------
// apb register offsets and fields
// ---------------------------------------------------------------
`define FPS_REG_CTRL      8'h00
`define FPS_REG_ADDR      8'h04
`define FPS_REG_WDATA     8'h08
`define FPS_REG_STATUS    8'h0C
`define FPS_CTRL_GO       0
`define FPS_CTRL_CMD_LO   1
`define FPS_CTRL_CMD_HI   3
`define FPS_CTRL_BYTE     4
`define FPS_ST_BUSY       0
`define FPS_ST_WINDOW     1
`define FPS_ST_FAIL       2
`define FPS_ST_REFUSED    3
`define FPS_ST_RDY        4
`define FPS_ST_ETIMER     5
`define FPS_ST_DATA_LO    16
// ---------------------------------------------------------------
// flash command codes and addresses
// ---------------------------------------------------------------
`define FPS_D_UNLOCK1     8'hAA
`define FPS_D_UNLOCK2     8'h55
`define FPS_D_PROGRAM     8'hA0
`define FPS_D_ERASE       8'h80
`define FPS_D_CHIP        8'h10
`define FPS_D_SECTOR      8'h30
`define FPS_D_RESET       8'hF0
`define FPS_A_UNLOCK1_W   19'h00555
`define FPS_A_UNLOCK2_W   19'h002AA
`define FPS_A_UNLOCK1_B   19'h00AAA
`define FPS_A_UNLOCK2_B   19'h00555
`define FPS_SA_LO_W       12
`define FPS_DQ_TIMER      3
`define FPS_DQ_TIMEOUT    5
`define FPS_DQ_TOGGLE     6
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define FPS_CLK_NS        8
`define FPS_SYNC_STAGES   2
`define FPS_T_AS_NS       16
`define FPS_T_WP_NS       35
`define FPS_T_DH_NS       16
`define FPS_T_ACC_NS      100
`define FPS_T_DF_NS       30
`define FPS_T_RP_NS       500
`define FPS_T_RH_NS       50
`define FPS_T_WINDOW_US   50
`define FPS_NS_UP(ns)     (((ns) + `FPS_CLK_NS - 1) / `FPS_CLK_NS)
`define FPS_WINDOW_CYC    ((`FPS_T_WINDOW_US * 1000) / `FPS_CLK_NS)
`endif

// >>> rtl/fps_pkg.sv
// types shared by the flash sequencer host
package fps_pkg;
  typedef enum logic [2:0] {
    FPS_CMD_PROGRAM,
    FPS_CMD_CHIP_ERASE,
    FPS_CMD_SECTOR_ERASE,
    FPS_CMD_ADD_SECTOR,
    FPS_CMD_RESET,
    FPS_CMD_READ,
    FPS_CMD_HW_RESET
  } fps_cmd_t;

  typedef enum {
    FPS_ST_IDLE,
    FPS_ST_SEQ,
    FPS_ST_WINDOW,
    FPS_ST_POLL1,
    FPS_ST_POLL2,
    FPS_ST_RST_PIN,
    FPS_ST_RST_WAIT
  } fps_state_t;

  typedef enum {
    FPS_PH_IDLE,
    FPS_PH_SETUP,
    FPS_PH_STROBE,
    FPS_PH_HOLD
  } fps_phase_t;

  typedef struct packed {
    logic        wr;
    logic [18:0] addr;
    logic [15:0] data;
  } fps_cycle_t;

  typedef struct packed {
    logic        ce_n;
    logic        we_n;
    logic        oe_n;
    logic [17:0] addr;
    logic [15:0] dq_out;
    logic [15:0] dq_oe;
  } fps_pins_t;
endpackage : fps_pkg

// >>> rtl/fps_bus_cycle.sv
// one flash bus cycle, write or read, on the parallel pins
`include "fps_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module fps_bus_cycle #(
  parameter int unsigned CNT_W = 8
) (
  // clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // request and answer
  input  wire logic                  req,
  input  wire fps_pkg::fps_cycle_t   cyc,
  input  wire logic                  byte_mode,
  input  wire logic                  abort,
  output logic                       done,
  output logic [15:0]                rdata,
  // flash pins
  output fps_pkg::fps_pins_t         pins,
  input  wire logic [15:0]           dq_in
);
  import fps_pkg::*;

  localparam logic [CNT_W-1:0] AS_CYC  = CNT_W'(`FPS_NS_UP(`FPS_T_AS_NS) - 1);
  localparam logic [CNT_W-1:0] WP_CYC  = CNT_W'(`FPS_NS_UP(`FPS_T_WP_NS) - 1);
  localparam logic [CNT_W-1:0] DH_CYC  = CNT_W'(`FPS_NS_UP(`FPS_T_DH_NS) - 1);
  localparam logic [CNT_W-1:0] ACC_CYC =
    CNT_W'(`FPS_NS_UP(`FPS_T_ACC_NS) + `FPS_SYNC_STAGES - 1);
  localparam logic [CNT_W-1:0] DF_CYC  = CNT_W'(`FPS_NS_UP(`FPS_T_DF_NS) - 1);

  fps_phase_t       phase_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic             wr_reg;
  logic [15:0]      dq_meta_reg;
  logic [15:0]      dq_sync_reg;

  wire              cnt_zero = (cnt_reg == '0);
  // in byte mode dq15 is the lowest address line and stays driven
  wire [15:0]       idle_oe  = byte_mode ? 16'h8000 : 16'h0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dq_meta_reg <= 16'h0000;
      dq_sync_reg <= 16'h0000;
    end else begin
      dq_meta_reg <= dq_in;
      dq_sync_reg <= dq_meta_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg <= FPS_PH_IDLE;
      cnt_reg   <= '0;
      wr_reg    <= 1'b0;
      done      <= 1'b0;
      rdata     <= 16'h0000;
      pins      <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, default: '0};
    end else begin
      done <= 1'b0;
      if (abort) begin
        phase_reg  <= FPS_PH_IDLE;
        pins.ce_n  <= 1'b1;
        pins.we_n  <= 1'b1;
        pins.oe_n  <= 1'b1;
        pins.dq_oe <= idle_oe;
      end else begin
        case (phase_reg)
          FPS_PH_IDLE: if (req) begin
            // address settles before the strobe falls, data before it rises
            phase_reg   <= FPS_PH_SETUP;
            cnt_reg     <= AS_CYC;
            wr_reg      <= cyc.wr;
            pins.addr   <= byte_mode ? cyc.addr[18:1] : cyc.addr[17:0];
            pins.dq_out <= byte_mode ? {cyc.addr[0], 7'h00, cyc.data[7:0]} : cyc.data;
            pins.dq_oe  <= cyc.wr ? 16'hFFFF : idle_oe;
          end
          FPS_PH_SETUP: if (cnt_zero) begin
            phase_reg <= FPS_PH_STROBE;
            cnt_reg   <= wr_reg ? WP_CYC : ACC_CYC;
            pins.ce_n <= 1'b0;
            pins.we_n <= ~wr_reg;
            pins.oe_n <= wr_reg;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
          FPS_PH_STROBE: if (cnt_zero) begin
            // both strobes rise together; data held on through the hold phase
            phase_reg <= FPS_PH_HOLD;
            cnt_reg   <= wr_reg ? DH_CYC : DF_CYC;
            pins.ce_n <= 1'b1;
            pins.we_n <= 1'b1;
            pins.oe_n <= 1'b1;
            if (!wr_reg) begin
              rdata <= byte_mode ? {8'h00, dq_sync_reg[7:0]} : dq_sync_reg;
            end
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
          FPS_PH_HOLD: if (cnt_zero) begin
            phase_reg  <= FPS_PH_IDLE;
            done       <= 1'b1;
            pins.dq_oe <= idle_oe;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
          default: phase_reg <= FPS_PH_IDLE;
        endcase
      end
    end
  end
endmodule : fps_bus_cycle
`default_nettype wire

// >>> rtl/fps_host.sv
// host controller that drives program and erase sequences into a parallel nor flash
//
// The address map and the APB register port were decided locally.
`include "fps_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module fps_host #(
  parameter int unsigned ADDR_W     = 8,
  parameter int unsigned WINDOW_CYC = `FPS_WINDOW_CYC
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // flash pins
  output logic                   flash_ce_n,
  output logic                   flash_we_n,
  output logic                   flash_oe_n,
  output logic [17:0]            flash_addr,
  output logic [15:0]            flash_dq_out,
  output logic [15:0]            flash_dq_oe,
  input  wire logic [15:0]       flash_dq_in,
  output logic                   flash_byte_n,
  output logic                   flash_reset_n,
  input  wire logic              flash_ready_busy_n
);
  import fps_pkg::*;

  localparam int unsigned TW = $clog2(WINDOW_CYC + 1);
  localparam logic [TW-1:0] WIN_LAST = TW'(WINDOW_CYC - 1);
  localparam logic [TW-1:0] RP_LAST  = TW'(`FPS_NS_UP(`FPS_T_RP_NS) - 1);
  localparam logic [TW-1:0] RH_LAST  = TW'(`FPS_NS_UP(`FPS_T_RH_NS) - 1);

  // ---------------------------------------------------------------
  // sequence tables
  // ---------------------------------------------------------------
  function automatic logic [18:0] sector_addr(logic [18:0] a, logic bm);
    logic [18:0] m;
    // only the top sector bits survive so any in-sector address works
    m = bm ? (19'h7FFFF << (`FPS_SA_LO_W + 1)) : (19'h3FFFF << `FPS_SA_LO_W);
    return a & m;
  endfunction : sector_addr

  function automatic logic [2:0] seq_last(fps_cmd_t c);
    case (c)
      FPS_CMD_PROGRAM:      return 3'd3;
      FPS_CMD_CHIP_ERASE,
      FPS_CMD_SECTOR_ERASE: return 3'd5;
      default:              return 3'd0;
    endcase
  endfunction : seq_last

  function automatic fps_cycle_t seq_cycle(fps_cmd_t c, logic [2:0] s, logic bm,
                                           logic [18:0] a, logic [15:0] d);
    logic [18:0] u1;
    logic [18:0] u2;
    fps_cycle_t  r;
    u1 = bm ? `FPS_A_UNLOCK1_B : `FPS_A_UNLOCK1_W;
    u2 = bm ? `FPS_A_UNLOCK2_B : `FPS_A_UNLOCK2_W;
    r  = '{wr: 1'b1, addr: u1, data: {8'h00, `FPS_D_UNLOCK1}};
    case (c)
      FPS_CMD_ADD_SECTOR: r = '{wr: 1'b1, addr: sector_addr(a, bm),
                                data: {8'h00, `FPS_D_SECTOR}};
      FPS_CMD_RESET:      r = '{wr: 1'b1, addr: 19'h00000,
                                data: {8'h00, `FPS_D_RESET}};
      FPS_CMD_READ:       r = '{wr: 1'b0, addr: a, data: 16'h0000};
      default: begin
        case (s)
          3'd1, 3'd4: r.addr = u2;
          default:    r.addr = u1;
        endcase
        case (s)
          3'd1, 3'd4: r.data = {8'h00, `FPS_D_UNLOCK2};
          3'd2: r.data = {8'h00, (c == FPS_CMD_PROGRAM) ? `FPS_D_PROGRAM : `FPS_D_ERASE};
          3'd3: if (c == FPS_CMD_PROGRAM) begin
            // any address in any sector; zero bits are never raised here
            r.addr = a;
            r.data = d;
          end
          3'd5: if (c == FPS_CMD_SECTOR_ERASE) begin
            r.addr = sector_addr(a, bm);
            r.data = {8'h00, `FPS_D_SECTOR};
          end else begin
            r.data = {8'h00, `FPS_D_CHIP};
          end
          default: ;
        endcase
      end
    endcase
    return r;
  endfunction : seq_cycle

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  fps_state_t  state_reg;
  fps_cmd_t    cmd_reg;
  logic [2:0]  step_reg;
  logic [TW-1:0] timer_reg;
  logic        dq5_seen_reg;
  logic        fail_reg;
  logic        refused_reg;
  logic [15:0] last_read_reg;
  logic [18:0] addr_reg;
  logic [15:0] wdata_reg;
  logic        req_reg;
  fps_cycle_t  cyc_reg;
  logic        rdy_meta_reg;
  logic        rdy_sync_reg;
  logic        cyc_done;
  logic [15:0] cyc_rdata;
  fps_pins_t   pins;

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  wire         access    = psel & penable & ~pready;
  wire         wr_en     = psel & penable & pready & pwrite;
  wire         sel_ctrl  = (paddr == ADDR_W'(`FPS_REG_CTRL));
  wire         sel_addr  = (paddr == ADDR_W'(`FPS_REG_ADDR));
  wire         sel_wdata = (paddr == ADDR_W'(`FPS_REG_WDATA));
  wire         sel_stat  = (paddr == ADDR_W'(`FPS_REG_STATUS));
  wire         mapped    = sel_ctrl | sel_addr | sel_wdata | sel_stat;
  wire         go        = wr_en & sel_ctrl & pwdata[`FPS_CTRL_GO];
  wire fps_cmd_t go_cmd  = fps_cmd_t'(pwdata[`FPS_CTRL_CMD_HI:`FPS_CTRL_CMD_LO]);
  wire         idle      = (state_reg == FPS_ST_IDLE);
  wire         in_window = (state_reg == FPS_ST_WINDOW);
  wire         byte_mode = ~flash_byte_n;
  wire         hw_reset  = go & (go_cmd == FPS_CMD_HW_RESET);
  // busy device ignores writes, so anything but the window follow-ups and the pin reset is refused
  wire         accept    = (idle & (go_cmd <= FPS_CMD_READ) & (go_cmd != FPS_CMD_ADD_SECTOR))
                         | (in_window & ((go_cmd == FPS_CMD_ADD_SECTOR)
                                        | (go_cmd == FPS_CMD_RESET)));
  wire         refuse    = go & ~accept & ~hw_reset;
  wire         toggling  = cyc_rdata[`FPS_DQ_TOGGLE] != last_read_reg[`FPS_DQ_TOGGLE];
  wire         poll_end  = (state_reg == FPS_ST_POLL2) & cyc_done;
  wire         fail_set  = poll_end & toggling & dq5_seen_reg;
  wire         clr_wr    = wr_en & sel_stat;
  wire fps_cycle_t rd_cycle = '{wr: 1'b0, addr: addr_reg, data: 16'h0000};
  wire [31:0]  status_word = {last_read_reg, 10'h0,
                              last_read_reg[`FPS_DQ_TIMER], rdy_sync_reg,
                              refused_reg, fail_reg, in_window, ~idle};
  wire [31:0]  rd_word   = sel_ctrl  ? {27'h0, byte_mode, 4'h0} :
                           sel_addr  ? {13'h0, addr_reg} :
                           sel_wdata ? {16'h0000, wdata_reg} :
                           sel_stat  ? status_word : 32'h00000000;

  // ---------------------------------------------------------------
  // apb registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= access;
      pslverr <= access & ~mapped;
      prdata  <= access ? rd_word : 32'h00000000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_reg     <= 19'h00000;
      wdata_reg    <= 16'h0000;
      flash_byte_n <= 1'b1;
    end else begin
      if (wr_en & sel_addr) addr_reg <= pwdata[18:0];
      if (wr_en & sel_wdata) wdata_reg <= pwdata[15:0];
      // width only changes between operations
      if (wr_en & sel_ctrl & idle) flash_byte_n <= ~pwdata[`FPS_CTRL_BYTE];
    end
  end

  // sticky flags: a new event wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fail_reg     <= 1'b0;
      refused_reg  <= 1'b0;
      rdy_meta_reg <= 1'b1;
      rdy_sync_reg <= 1'b1;
    end else begin
      fail_reg     <= fail_set | (fail_reg & ~(clr_wr & pwdata[`FPS_ST_FAIL]));
      refused_reg  <= refuse | (refused_reg & ~(clr_wr & pwdata[`FPS_ST_REFUSED]));
      rdy_meta_reg <= flash_ready_busy_n;
      rdy_sync_reg <= rdy_meta_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_read_reg <= 16'h0000;
    end else if (cyc_done & ~cyc_reg.wr) begin
      last_read_reg <= cyc_rdata;
    end
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg     <= FPS_ST_IDLE;
      cmd_reg       <= FPS_CMD_PROGRAM;
      step_reg      <= 3'd0;
      timer_reg     <= '0;
      dq5_seen_reg  <= 1'b0;
      req_reg       <= 1'b0;
      cyc_reg       <= '0;
      flash_reset_n <= 1'b1;
    end else begin
      req_reg <= 1'b0;
      if (hw_reset) begin
        // reset pin ends whatever runs; software reissues the sequence
        state_reg     <= FPS_ST_RST_PIN;
        flash_reset_n <= 1'b0;
        timer_reg     <= RP_LAST;
      end else if (go & accept) begin
        cmd_reg      <= go_cmd;
        step_reg     <= 3'd0;
        dq5_seen_reg <= 1'b0;
        req_reg      <= 1'b1;
        cyc_reg      <= seq_cycle(go_cmd, 3'd0, byte_mode, addr_reg, wdata_reg);
        state_reg    <= FPS_ST_SEQ;
      end else begin
        case (state_reg)
          FPS_ST_SEQ: if (cyc_done) begin
            if (step_reg != seq_last(cmd_reg)) begin
              step_reg <= step_reg + 3'd1;
              req_reg  <= 1'b1;
              cyc_reg  <= seq_cycle(cmd_reg, step_reg + 3'd1, byte_mode, addr_reg, wdata_reg);
            end else if (cmd_reg == FPS_CMD_PROGRAM || cmd_reg == FPS_CMD_CHIP_ERASE) begin
              // device runs its own pulses; only status polling from here
              state_reg <= FPS_ST_POLL1;
              req_reg   <= 1'b1;
              cyc_reg   <= rd_cycle;
            end else if (cmd_reg == FPS_CMD_SECTOR_ERASE || cmd_reg == FPS_CMD_ADD_SECTOR) begin
              // window restarts at the end of every sector write
              state_reg <= FPS_ST_WINDOW;
              timer_reg <= WIN_LAST;
            end else begin
              state_reg <= FPS_ST_IDLE;
            end
          end
          FPS_ST_WINDOW: if (timer_reg == '0) begin
            state_reg <= FPS_ST_POLL1;
            req_reg   <= 1'b1;
            cyc_reg   <= rd_cycle;
          end else begin
            timer_reg <= timer_reg - 1'b1;
          end
          FPS_ST_POLL1: if (cyc_done) begin
            state_reg <= FPS_ST_POLL2;
            req_reg   <= 1'b1;
            cyc_reg   <= rd_cycle;
          end
          FPS_ST_POLL2: if (cyc_done) begin
            if (!toggling) begin
              // toggle stopped: the device is back in array read
              state_reg <= FPS_ST_IDLE;
            end else if (dq5_seen_reg) begin
              // still toggling after timeout flag: force array read
              cmd_reg  <= FPS_CMD_RESET;
              step_reg <= 3'd0;
              state_reg <= FPS_ST_SEQ;
              req_reg  <= 1'b1;
              cyc_reg  <= seq_cycle(FPS_CMD_RESET, 3'd0, byte_mode, addr_reg, wdata_reg);
            end else begin
              dq5_seen_reg <= cyc_rdata[`FPS_DQ_TIMEOUT];
              req_reg      <= 1'b1;
              cyc_reg      <= rd_cycle;
            end
          end
          FPS_ST_RST_PIN: if (timer_reg == '0) begin
            flash_reset_n <= 1'b1;
            timer_reg     <= RH_LAST;
            state_reg     <= FPS_ST_RST_WAIT;
          end else begin
            timer_reg <= timer_reg - 1'b1;
          end
          FPS_ST_RST_WAIT: if (timer_reg == '0) begin
            state_reg <= FPS_ST_IDLE;
          end else begin
            timer_reg <= timer_reg - 1'b1;
          end
          default: state_reg <= FPS_ST_IDLE;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // pin engine
  // ---------------------------------------------------------------
  fps_bus_cycle #(
    .CNT_W (8)
  ) u_cycle (
    .pclk      (pclk),
    .presetn   (presetn),
    .req       (req_reg),
    .cyc       (cyc_reg),
    .byte_mode (byte_mode),
    .abort     (hw_reset),
    .done      (cyc_done),
    .rdata     (cyc_rdata),
    .pins      (pins),
    .dq_in     (flash_dq_in)
  );

  assign flash_ce_n   = pins.ce_n;
  assign flash_we_n   = pins.we_n;
  assign flash_oe_n   = pins.oe_n;
  assign flash_addr   = pins.addr;
  assign flash_dq_out = pins.dq_out;
  assign flash_dq_oe  = pins.dq_oe;
endmodule : fps_host
`default_nettype wire

// >>> verification/fps_flash_model.sv
// behavioural flash device answering the sequencer host
`timescale 1ns/1ps
`default_nettype none
module fps_flash_model #(parameter int PROG_T = 150, ERASE_T = 300, WIN_T = 100) (
  // strobes, address and bus level
  input wire logic ce_n, we_n, oe_n, reset_n,
  input wire logic [17:0] addr,
  input wire logic [15:0] dq_o,
  // answer
  output logic [15:0] dq_i,
  output logic rb_n
);
  // timers tick every 10 ns; erase writes ones back at the end
  logic [15:0] mem [logic [17:0]];
  logic [63:0] secs = 64'h0;
  logic [17:0] a = 18'h0;
  logic [15:0] q = 16'h0;
  logic [7:0] d;
  logic tog = 1'b0;
  int st = 0, busy = 0, win = 0;
  wire ws_n = ce_n | we_n;
  assign d = dq_o[7:0];
  function automatic logic [15:0] rd(input logic [17:0] k);
    return mem.exists(k) ? mem[k] : 16'hFFFF;
  endfunction : rd
  always @(negedge ws_n) a = addr;
  always @(posedge ws_n or negedge reset_n)
    if (!reset_n) begin
      st = 0; busy = 0; win = 0; secs = 64'h0;
    end else if (busy == 0) begin
      if (win > 0) begin
        if (d == 8'h30) secs[a[17:12]] = 1'b1;
        else secs = 64'h0;
        win = (d == 8'h30) ? WIN_T : 0;
      end else case (st)
        0: st = (d == 8'hAA) ? 1 : 0;
        1: st = (d == 8'h55) ? 2 : 0;
        2: st = (d == 8'hA0) ? 6 : (d == 8'h80) ? 3 : 0;
        3: st = (d == 8'hAA) ? 4 : 0;
        4: st = (d == 8'h55) ? 5 : 0;
        5: begin
          if (d == 8'h10) secs = '1;
          if (d == 8'h10) busy = ERASE_T;
          if (d == 8'h30) secs[a[17:12]] = 1'b1;
          if (d == 8'h30) win = WIN_T;
          st = 0;
        end
        default: begin
          mem[a] = rd(a) & dq_o;
          busy = PROG_T;
          st = 0;
        end
      endcase
    end
  always #10 begin
    if (win == 1) busy = ERASE_T;
    if (win > 0) win--;
    if (busy == 1) foreach (mem[k]) if (secs[k[17:12]]) mem[k] = 16'hFFFF;
    if (busy == 1) secs = 64'h0;
    if (busy > 0) busy--;
  end
  always @(negedge oe_n) begin
    tog = ~tog;
    q = (busy > 0 || win > 0) ? {9'h000, tog, 2'b00, win == 0, tog & (secs != 0), 2'b00}
                              : rd(addr);
  end
  // a released bus never repeats its last value
  assign dq_i = (!ce_n && !oe_n) ? q : ~q;
  assign rb_n = (busy > 0 || win > 0) ? 1'b0 : 1'b1;
endmodule : fps_flash_model
`default_nettype wire

// >>> verification/fps_host_asserts.sv
// checker of apb answers and flash pin cycles of the sequencer host
`timescale 1ns/1ps
`default_nettype none
module fps_host_asserts #(parameter int unsigned ADDR_W = 8) (
  // apb side
  input wire logic pclk, presetn, psel, penable, pready, pslverr,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  // flash pins
  input wire logic flash_ce_n, flash_we_n, flash_oe_n, flash_reset_n,
  input wire logic [17:0] flash_addr,
  input wire logic [15:0] flash_dq_out, flash_dq_oe
);
  logic [6:0] low_cnt;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) low_cnt <= 7'h00;
    else low_cnt <= flash_reset_n ? 7'h00 : low_cnt + 7'h01;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_one_wait: assert property (psel && !penable |-> !pready ##1 !pready ##1 pready)
    else $error("apb answer not after one wait state");
  a_err_map: assert property (pready && paddr > 8'h0C |-> pslverr)
    else $error("unmapped access without error");
  a_rdata_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer cycle");
  a_strobe_len: assert property (@(posedge pclk) disable iff (!presetn || !flash_reset_n)
    $fell(flash_we_n) |-> !flash_ce_n && flash_oe_n ##1 !flash_we_n [*4] ##1 flash_we_n)
    else $error("write strobe not five cycles");
  a_write_setup: assert property ($fell(flash_we_n) |-> $stable(flash_addr)
    && $stable(flash_dq_out) && $past(flash_dq_oe[7:0]) == 8'hFF)
    else $error("address or data moved at strobe");
  a_read_bus: assert property (!flash_oe_n |-> flash_we_n && flash_dq_oe[14:0] == 15'h0)
    else $error("host drives bus during read");
  a_unlock_addr: assert property ($fell(flash_we_n) && flash_dq_out[7:0] == 8'hAA
    |-> flash_addr[10:0] == 11'h555) else $error("unlock write off its address");
  a_sector_mask: assert property ($fell(flash_we_n) && flash_dq_out[7:0] == 8'h30
    |-> flash_addr[11:0] == 12'h000) else $error("sector address not masked");
  a_reset_cmd: assert property ($fell(flash_we_n) && flash_dq_out[7:0] == 8'hF0
    |-> flash_addr == 18'h0) else $error("reset command off address zero");
  a_reset_len: assert property ($rose(flash_reset_n) |-> low_cnt == 7'd63)
    else $error("reset pin pulse not 63 cycles");
  c_err: cover property (pready && pslverr);
  c_pin_reset: cover property ($rose(flash_reset_n));
  c_sector: cover property ($fell(flash_we_n) && flash_dq_out[7:0] == 8'h30);
endmodule : fps_host_asserts
bind fps_host fps_host_asserts #(.ADDR_W(ADDR_W)) u_chk (.pclk, .presetn, .psel, .penable,
  .pready, .pslverr, .paddr, .prdata, .flash_ce_n, .flash_we_n, .flash_oe_n, .flash_reset_n,
  .flash_addr, .flash_dq_out, .flash_dq_oe);
`default_nettype wire

// >>> verification/test_fps_host.sv
// self-checking bench: apb tasks drive the host against the flash model
`timescale 1ns/1ps
`default_nettype none
module test_fps_host;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, ev;
  logic ce_n, we_n, oe_n, byte_n, rst_n, rb_n;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic [17:0] fa;
  logic [15:0] dqo, dqoe, dq, mdq;
  int errors = 0, check_count = 0, cyc = 0;
  always #4 pclk = ~pclk;
  // bus level from the host's enables, model value on undriven bits
  assign dq = (dqoe & dqo) | (~dqoe & mdq);
  fps_host #(.WINDOW_CYC(50)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .flash_ce_n(ce_n), .flash_we_n(we_n),
    .flash_oe_n(oe_n), .flash_addr(fa), .flash_dq_out(dqo), .flash_dq_oe(dqoe),
    .flash_dq_in(dq), .flash_byte_n(byte_n), .flash_reset_n(rst_n), .flash_ready_busy_n(rb_n));
  fps_flash_model FLASH (.ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .reset_n(rst_n), .addr(fa),
    .dq_o(dq), .dq_i(mdq), .rb_n(rb_n));
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task automatic idle(); do apb(1'b0, 8'h0C, 32'h0); while (rv[0] !== 1'b0); endtask : idle
  task automatic in_window(); do apb(1'b0, 8'h0C, 32'h0); while (rv[1] !== 1'b1); endtask : in_window
  task automatic go(input logic [2:0] c, input logic [18:0] a);
    apb(1'b1, 8'h04, {13'h0, a});
    apb(1'b1, 8'h00, {27'h0, ~byte_n, c, 1'b1});
  endtask : go
  task automatic prog(input logic [18:0] a, input logic [15:0] d);
    apb(1'b1, 8'h08, {16'h0, d});
    go(3'd0, a);
    idle();
  endtask : prog
  task automatic look(input logic [18:0] a, input logic [15:0] e);
    go(3'd5, a);
    idle();
    chk({16'h0, rv[31:16]}, {16'h0, e});
  endtask : look
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h0C, 32'h0); chk(rv, 32'h10);
    apb(1'b0, 8'h10, 32'h0); chk({31'h0, ev}, 32'h1);
    prog(19'h01234, 16'h12C3); look(19'h01234, 16'h12C3);
    prog(19'h3F000, 16'h3C3C); look(19'h3F000, 16'h3C3C);
    prog(19'h01234, 16'h4C5C); look(19'h01234, 16'h0040);
    go(3'd0, 19'h02000); go(3'd5, 19'h02000); idle(); chk({31'h0, rv[3]}, 32'h1);
    apb(1'b1, 8'h0C, 32'h8);
    prog(19'h03000, 16'h1E1E); go(3'd0, 19'h03000);
    repeat (8) apb(1'b0, 8'h0C, 32'h0);
    go(3'd6, 19'h0); idle(); chk({31'h0, rv[4]}, 32'h1);
    prog(19'h03000, 16'h1E1E); look(19'h03000, 16'h1E1E);
    go(3'd2, 19'h02000); in_window(); go(3'd4, 19'h0); idle(); look(19'h02000, 16'h4C5C);
    go(3'd2, 19'h01234); in_window(); go(3'd3, 19'h3F000); idle();
    look(19'h01234, 16'hFFFF); look(19'h3F000, 16'hFFFF);
    look(19'h02000, 16'h4C5C);
    go(3'd1, 19'h0); idle(); look(19'h02000, 16'hFFFF);
    apb(1'b1, 8'h00, 32'h10); idle(); chk({31'h0, byte_n}, 32'h0);
    prog(19'h04001, 16'h00A5); look(19'h04001, 16'h00A5);
    print_verdict();
  end
  // hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 60000) begin
      errors++;
      print_verdict();
    end
  end
endmodule : test_fps_host
`default_nettype wire
